/* File: logic/quad_phase_fetch_execute_sequencer.sv */
// What this block does
// - Divide clock by four into phases.
// - Increment program counter in phase one.
// - Latch fetched word at phase four.
// - Execute latched word in next cycle.
// - Read operand phase two, write phase four.
// - Overlap fetch with execute, one per cycle.
// - Branch flushes fetched word, two cycles.
// - Page bit in status selects page.
// - Pointer register selects data bank.
// - Quarter-rate clock out in RC modes.
// - Software pull-up and wake on pins.
// - Master-clear pin keeps pull-up on.
// - Bit three is input only.
// - Program counter is ten bits.
// - Wrap fetches; start at address zero.
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module quad_phase_fetch_execute_sequencer
  import sequencer_pkg::*;
#(
  parameter int ADDR_BITS = COUNTER_WIDTH,
  parameter int IMPL_BITS = IMPL_WIDTH
)
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic [ADDR_BITS-1:0]        programAddress,
  output logic                        programRead,
  input  wire logic [INSTR_WIDTH-1:0] programData,
  output logic [7:0]                  dataAddress,
  output logic                        dataRead,
  output logic                        dataWrite,
  output logic [7:0]                  dataWriteValue,
  input  wire logic [7:0]             dataReadValue,
  input  wire logic                   branchTaken,
  input  wire logic [ADDR_BITS-1:0]   branchTarget,
  input  wire logic [7:0]             operandAddress,
  input  wire logic [7:0]             resultValue,
  input  wire logic                   resultWrite,
  output logic [INSTR_WIDTH-1:0]      executeWord,
  output logic                        executeValid,
  output logic [7:0]                  operandValue,
  output logic                        phaseOne,
  output logic                        phaseTwo,
  output logic                        phaseThree,
  output logic                        phaseFour,
  input  wire logic [PORTB_WIDTH-1:0] portBIn,
  output logic [PORTB_WIDTH-1:0]      portBOut,
  output logic [PORTB_WIDTH-1:0]      portBOe,
  output logic [PORTB_WIDTH-1:0]      portBPullup,
  output logic                        wakeOnChange
);

  // ==========================================================================
  // Helpers.
  // ==========================================================================
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[i*8 +: 8] = val[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [ADDR_BITS-1:0] wrapAddr(input logic [ADDR_BITS-1:0] a);
    logic [ADDR_BITS-1:0] m;
    m = '0;
    m[IMPL_BITS-1:0] = '1;
    return a & m;
  endfunction

  // ==========================================================================
  // Registers.
  // ==========================================================================
  logic [31:0] ctrl;
  logic [7:0]  status;
  logic [7:0]  pointer;
  logic [31:0] portReg;
  logic [31:0] next_ctrl;
  logic [7:0]  next_status;
  logic [7:0]  next_pointer;
  logic [31:0] next_portReg;

  logic        run;
  clk_mode_t   clkMode;
  logic        quarterClock;

  assign run     = ctrl[CTRL_RUN_BIT];
  assign clkMode = clk_mode_t'(ctrl[CTRL_MODE_LSB +: 2]);

  phase_divider u_phase
  (
    .clk          (clk),
    .rst          (rst),
    .run          (run),
    .phaseOne     (phaseOne),
    .phaseTwo     (phaseTwo),
    .phaseThree   (phaseThree),
    .phaseFour    (phaseFour),
    .quarterClock (quarterClock)
  );

  // ==========================================================================
  // Fetch and execute pipeline.
  // ==========================================================================
  logic [ADDR_BITS-1:0]   programCounter;
  logic [ADDR_BITS-1:0]   fetchAddr;
  logic [INSTR_WIDTH-1:0] instructionRegister;
  logic                   wordValid;
  logic                   fetchValid;
  logic [7:0]             operand;
  logic [ADDR_BITS-1:0]   next_programCounter;
  logic [ADDR_BITS-1:0]   next_fetchAddr;
  logic [INSTR_WIDTH-1:0] next_instructionRegister;
  logic                   next_wordValid;
  logic                   next_fetchValid;
  logic [7:0]             next_operand;
  logic [ADDR_BITS-1:0]   pagedTarget;

  always_comb
  begin
    pagedTarget = branchTarget;
    if (ADDR_BITS > 9)
    begin
      pagedTarget[ADDR_BITS-1] = status[STATUS_PAGE_BIT];
    end
  end

  always_comb
  begin
    next_programCounter = programCounter;
    next_fetchAddr = fetchAddr;
    next_instructionRegister = instructionRegister;
    next_wordValid = wordValid;
    next_fetchValid = fetchValid;
    next_operand = operand;
    if (phaseOne)
    begin
      next_fetchAddr = wrapAddr(programCounter);
      next_programCounter = programCounter + 1'b1;
      next_fetchValid = 1'b1;
    end
    if (phaseTwo && wordValid)
    begin
      next_operand = dataReadValue;
    end
    if (phaseFour)
    begin
      next_instructionRegister = programData;
      next_wordValid = fetchValid;
      if (wordValid && branchTaken)
      begin
        next_programCounter = pagedTarget;
        next_wordValid = 1'b0;
        next_instructionRegister = NOP_WORD;
      end
      next_fetchValid = 1'b0;
    end
    if (rst)
    begin
      next_programCounter = RESET_VECTOR;
      next_fetchAddr = RESET_VECTOR;
      next_instructionRegister = NOP_WORD;
      next_wordValid = 1'b0;
      next_fetchValid = 1'b0;
      next_operand = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    programCounter      <= next_programCounter;
    fetchAddr           <= next_fetchAddr;
    instructionRegister <= next_instructionRegister;
    wordValid           <= next_wordValid;
    fetchValid          <= next_fetchValid;
    operand             <= next_operand;
  end

  assign programAddress = fetchAddr;
  assign programRead    = fetchValid && phaseFour;
  assign executeWord    = instructionRegister;
  assign executeValid   = wordValid && (phaseTwo || phaseThree || phaseFour);
  assign operandValue   = operand;
  assign dataRead       = wordValid && phaseTwo;
  assign dataWrite      = wordValid && phaseFour && resultWrite;
  assign dataWriteValue = resultValue;

  always_comb
  begin
    dataAddress = operandAddress;
    if (operandAddress[4:0] == 5'h00)
    begin
      dataAddress = pointer;
    end
    else if (operandAddress[4])
    begin
      dataAddress = {pointer[7:POINTER_BANK_LSB], operandAddress[4:0]};
    end
  end

  // ==========================================================================
  // Port pins.
  // ==========================================================================
  port_pin_control u_pins
  (
    .clk             (clk),
    .rst             (rst),
    .latchB          (portReg[PORTB_WIDTH-1:0]),
    .trisB           (portReg[8 +: PORTB_WIDTH]),
    .pullupSel       (ctrl[CTRL_PULLUP_LSB +: PORTB_WIDTH]),
    .wakeSel         (ctrl[CTRL_WAKE_LSB +: PORTB_WIDTH]),
    .masterClearMode (ctrl[CTRL_CLEAR_BIT]),
    .clockOutMode    ((clkMode == CLK_MODE_EXTERNAL_RC) || (clkMode == CLK_MODE_INTERNAL_OSC)),
    .quarterClock    (quarterClock),
    .portBIn         (portBIn),
    .portBOut        (portBOut),
    .portBOe         (portBOe),
    .portBPullup     (portBPullup),
    .wakeOnChange    (wakeOnChange)
  );

  // ==========================================================================
  // AXI4-Lite slave.
  // ==========================================================================
  logic       awHeld;
  logic       wHeld;
  logic [7:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic [1:0] bResp;
  logic       bValid;
  logic [31:0] rData;
  logic [1:0] rResp;
  logic       rValid;
  logic       next_awHeld;
  logic       next_wHeld;
  logic [7:0] next_awAddr;
  logic [31:0] next_wData;
  logic [3:0] next_wStrb;
  logic [1:0] next_bResp;
  logic       next_bValid;
  logic [31:0] next_rData;
  logic [1:0] next_rResp;
  logic       next_rValid;

  assign s_axi_awready = !awHeld && !bValid;
  assign s_axi_wready  = !wHeld && !bValid;
  assign s_axi_arready = !rValid;
  assign s_axi_bvalid  = bValid;
  assign s_axi_bresp   = bResp;
  assign s_axi_rvalid  = rValid;
  assign s_axi_rdata   = rData;
  assign s_axi_rresp   = rResp;

  always_comb
  begin
    next_awHeld = awHeld;
    next_wHeld = wHeld;
    next_awAddr = awAddr;
    next_wData = wData;
    next_wStrb = wStrb;
    next_bResp = bResp;
    next_bValid = bValid;
    next_rData = rData;
    next_rResp = rResp;
    next_rValid = rValid;
    next_ctrl = ctrl;
    next_status = status;
    next_pointer = pointer;
    next_portReg = portReg;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_awHeld = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
    end
    if (awHeld && wHeld)
    begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bValid = 1'b1;
      next_bResp = AXI_OKAY;
      unique case (awAddr)
        CTRL_OFFSET:    next_ctrl = merge(ctrl, wData, wStrb);
        STATUS_OFFSET:  next_status = wStrb[0] ? wData[7:0] : status;
        POINTER_OFFSET: next_pointer = wStrb[0] ? wData[7:0] : pointer;
        PORT_OFFSET:    next_portReg = merge(portReg, wData, wStrb) & 32'h0000_3F3F;
        default:        next_bResp = AXI_SLVERR;
      endcase
    end
    if (bValid && s_axi_bready)
    begin
      next_bValid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rValid = 1'b1;
      next_rResp = AXI_OKAY;
      unique case (s_axi_araddr)
        CTRL_OFFSET:    next_rData = ctrl;
        STATUS_OFFSET:  next_rData = {24'h00_0000, status};
        POINTER_OFFSET: next_rData = {24'h00_0000, pointer};
        PORT_OFFSET:    next_rData = {16'h0000, portReg[15:8], 2'h0, portBIn};
        PCVIEW_OFFSET:  next_rData = {{(32-ADDR_BITS){1'b0}}, programCounter};
        IRVIEW_OFFSET:  next_rData = {wordValid, 19'h0_0000, instructionRegister};
        default:
        begin
          next_rData = '0;
          next_rResp = AXI_SLVERR;
        end
      endcase
    end
    else if (rValid && s_axi_rready)
    begin
      next_rValid = 1'b0;
    end
    if (rst)
    begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_awAddr = '0;
      next_wData = '0;
      next_wStrb = '0;
      next_bResp = AXI_OKAY;
      next_bValid = 1'b0;
      next_rData = '0;
      next_rResp = AXI_OKAY;
      next_rValid = 1'b0;
      next_ctrl = CTRL_RESET;
      next_status = STATUS_RESET;
      next_pointer = POINTER_RESET;
      next_portReg = {18'h0_0000, TRIS_RESET, 8'h00};
    end
  end

  always_ff @(posedge clk)
  begin
    awHeld  <= next_awHeld;
    wHeld   <= next_wHeld;
    awAddr  <= next_awAddr;
    wData   <= next_wData;
    wStrb   <= next_wStrb;
    bResp   <= next_bResp;
    bValid  <= next_bValid;
    rData   <= next_rData;
    rResp   <= next_rResp;
    rValid  <= next_rValid;
    ctrl    <= next_ctrl;
    status  <= next_status;
    pointer <= next_pointer;
    portReg <= next_portReg;
  end

endmodule
`default_nettype wire

/* File: logic/sequencer_pkg.sv */
package sequencer_pkg;

  // ==========================================================================
  // Register map, one aligned 32-bit word each.
  // ==========================================================================
  localparam logic [7:0] CTRL_OFFSET    = 8'h00;
  localparam logic [7:0] STATUS_OFFSET  = 8'h04;
  localparam logic [7:0] POINTER_OFFSET = 8'h08;
  localparam logic [7:0] PORT_OFFSET    = 8'h0C;
  localparam logic [7:0] PCVIEW_OFFSET  = 8'h10;
  localparam logic [7:0] IRVIEW_OFFSET  = 8'h14;

  // ==========================================================================
  // Control register fields.
  // ==========================================================================
  localparam int CTRL_RUN_BIT      = 0;
  localparam int CTRL_MODE_LSB     = 1;
  localparam int CTRL_CLEAR_BIT    = 3;
  localparam int CTRL_PULLUP_LSB   = 8;
  localparam int CTRL_WAKE_LSB     = 16;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  // ==========================================================================
  // Status, pointer and port fields.
  // ==========================================================================
  localparam int STATUS_PAGE_BIT     = 5;
  localparam logic [7:0] STATUS_RESET = 8'h18;
  localparam logic [7:0] POINTER_RESET = 8'h80;
  localparam int POINTER_BANK_LSB    = 5;
  localparam int PORTB_WIDTH         = 6;
  localparam int PORTC_WIDTH         = 6;
  localparam logic [5:0] WEAK_CAPABLE = 6'h1B;
  localparam int QCLK_BIT            = 4;
  localparam int CLEAR_PIN_BIT       = 3;
  localparam logic [5:0] TRIS_RESET  = 6'h3F;

  // ==========================================================================
  // Program space.
  // ==========================================================================
  localparam int COUNTER_WIDTH       = 10;
  localparam int IMPL_WIDTH          = 10;
  localparam int INSTR_WIDTH         = 12;
  localparam logic [9:0] RESET_VECTOR = 10'h000;
  localparam logic [11:0] NOP_WORD   = 12'h000;

  typedef enum logic [1:0] {
    CLK_MODE_XTAL,
    CLK_MODE_EXTERNAL_RC,
    CLK_MODE_INTERNAL_OSC,
    CLK_MODE_EC
  } clk_mode_t;

  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

endpackage

/* File: logic/phase_divider.sv */
`timescale 1ns/1ps
`default_nettype none
module phase_divider
  import sequencer_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic run,
  output logic      phaseOne,
  output logic      phaseTwo,
  output logic      phaseThree,
  output logic      phaseFour,
  output logic      quarterClock
);

  // ==========================================================================
  // Four-phase counter.
  // ==========================================================================
  typedef enum logic [1:0] {P_ONE, P_TWO, P_THREE, P_FOUR} phase_t;
  phase_t phase;
  phase_t next_phase;

  always_comb
  begin
    next_phase = phase;
    if (rst || !run)
    begin
      next_phase = P_ONE;
    end
    else
    begin
      unique case (phase)
        P_ONE:   next_phase = P_TWO;
        P_TWO:   next_phase = P_THREE;
        P_THREE: next_phase = P_FOUR;
        P_FOUR:  next_phase = P_ONE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    phase <= next_phase;
  end

  assign phaseOne     = run && (phase == P_ONE);
  assign phaseTwo     = run && (phase == P_TWO);
  assign phaseThree   = run && (phase == P_THREE);
  assign phaseFour    = run && (phase == P_FOUR);
  assign quarterClock = (phase == P_THREE) || (phase == P_FOUR);

endmodule
`default_nettype wire

/* File: logic/port_pin_control.sv */
`timescale 1ns/1ps
`default_nettype none
module port_pin_control
  import sequencer_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic [PORTB_WIDTH-1:0] latchB,
  input  wire logic [PORTB_WIDTH-1:0] trisB,
  input  wire logic [PORTB_WIDTH-1:0] pullupSel,
  input  wire logic [PORTB_WIDTH-1:0] wakeSel,
  input  wire logic                   masterClearMode,
  input  wire logic                   clockOutMode,
  input  wire logic                   quarterClock,
  input  wire logic [PORTB_WIDTH-1:0] portBIn,
  output logic      [PORTB_WIDTH-1:0] portBOut,
  output logic      [PORTB_WIDTH-1:0] portBOe,
  output logic      [PORTB_WIDTH-1:0] portBPullup,
  output logic                        wakeOnChange
);

  // ==========================================================================
  // Pin drive, pull-ups and change detection.
  // ==========================================================================
  logic [PORTB_WIDTH-1:0] lastIn;
  logic [PORTB_WIDTH-1:0] next_lastIn;
  logic [PORTB_WIDTH-1:0] next_portBOut;
  logic [PORTB_WIDTH-1:0] next_portBOe;
  logic [PORTB_WIDTH-1:0] next_portBPullup;
  logic                   next_wakeOnChange;

  always_comb
  begin
    next_lastIn = portBIn;
    next_portBOut = latchB;
    next_portBOe = ~trisB;
    next_portBOe[CLEAR_PIN_BIT] = 1'b0;
    if (clockOutMode)
    begin
      next_portBOut[QCLK_BIT] = quarterClock;
      next_portBOe[QCLK_BIT] = 1'b1;
    end
    next_portBPullup = pullupSel & WEAK_CAPABLE;
    if (masterClearMode)
    begin
      next_portBPullup[CLEAR_PIN_BIT] = 1'b1;
    end
    next_wakeOnChange = |((portBIn ^ lastIn) & wakeSel & WEAK_CAPABLE);
    if (rst)
    begin
      next_lastIn = '0;
      next_portBOut = '0;
      next_portBOe = '0;
      next_portBPullup = '0;
      next_wakeOnChange = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    lastIn       <= next_lastIn;
    portBOut     <= next_portBOut;
    portBOe      <= next_portBOe;
    portBPullup  <= next_portBPullup;
    wakeOnChange <= next_wakeOnChange;
  end

endmodule
`default_nettype wire

/* File: verification/sequencer_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module sequencer_assertions
  import sequencer_pkg::*;
#(
  parameter int ADDR_BITS = COUNTER_WIDTH
)
(
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic [ADDR_BITS-1:0]   programAddress,
  input wire logic                   programRead,
  input wire logic [INSTR_WIDTH-1:0] programData,
  input wire logic                   dataRead,
  input wire logic                   dataWrite,
  input wire logic [7:0]             dataReadValue,
  input wire logic                   branchTaken,
  input wire logic [ADDR_BITS-1:0]   branchTarget,
  input wire logic                   resultWrite,
  input wire logic [INSTR_WIDTH-1:0] executeWord,
  input wire logic                   executeValid,
  input wire logic [7:0]             operandValue,
  input wire logic                   phaseOne,
  input wire logic                   phaseTwo,
  input wire logic                   phaseThree,
  input wire logic                   phaseFour,
  input wire logic [PORTB_WIDTH-1:0] portBOe
);
  localparam logic [ADDR_BITS-1:0] LOW = {1'b0, {(ADDR_BITS-1){1'b1}}};
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================================================
  // Phase, fetch and execute timing, and the input-only pin.
  AST_PHASE_ORDER: assert property (phaseOne |=> phaseTwo ##1 phaseThree ##1 phaseFour ##1 phaseOne)
    else $error("phase order broken");
  AST_PHASE_EXCL: assert property ($onehot0({phaseOne, phaseTwo, phaseThree, phaseFour}))
    else $error("phases overlap");
  AST_PC_STEP: assert property (programRead && !(branchTaken && executeValid)
    |-> ##4 programRead && programAddress == $past(programAddress, 4) + 1'b1)
    else $error("fetch address did not step");
  AST_BRANCH_TARGET: assert property (programRead && branchTaken && executeValid
    |-> ##4 programRead && ((programAddress ^ $past(branchTarget, 4)) & LOW) == '0)
    else $error("branch target not fetched");
  AST_BRANCH_FLUSH: assert property (phaseFour && branchTaken && executeValid |=> !executeValid [*4])
    else $error("fetched word not flushed");
  AST_LATCH_EXEC: assert property (programRead && !(branchTaken && executeValid)
    |-> ##2 (executeValid && executeWord == $past(programData, 2)) ##1 executeValid ##1 executeValid)
    else $error("fetched word not executed");
  AST_READ_PHASE: assert property (dataRead == (phaseTwo && executeValid))
    else $error("operand read outside phase two");
  AST_WRITE_PHASE: assert property (dataWrite == (phaseFour && executeValid && resultWrite))
    else $error("result write outside phase four");
  AST_OPERAND: assert property (dataRead |=> operandValue == $past(dataReadValue))
    else $error("operand not captured");
  AST_INPUT_ONLY: assert property (!portBOe[CLEAR_PIN_BIT])
    else $error("input-only pin driven");
  AST_RESET_START: assert property ($fell(rst) |-> phaseOne && !executeValid ##1 !executeValid [*3] ##2 executeValid)
    else $error("restart not clean");
endmodule
bind quad_phase_fetch_execute_sequencer sequencer_assertions #(.ADDR_BITS(ADDR_BITS)) checker_inst (.*);
`default_nettype wire

/* File: verification/fetch_memory_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fetch_memory_model
  import sequencer_pkg::*;
(
  input wire logic                   clk,
  input wire logic [COUNTER_WIDTH-1:0] programAddress,
  input wire logic                   programRead,
  output logic     [INSTR_WIDTH-1:0] programData,
  input wire logic [7:0]             dataAddress,
  input wire logic                   dataRead,
  input wire logic                   dataWrite,
  input wire logic [7:0]             dataWriteValue,
  output logic     [7:0]             dataReadValue
);
  logic [7:0]  cells [256];
  logic [11:0] lastWord = 12'h000;
  logic [7:0]  lastByte = 8'h00;
  // Released lines show the inverse of the last value.
  assign programData = programRead ? {programAddress, 2'b01} : ~lastWord;
  assign dataReadValue = dataRead ? cells[dataAddress] : ~lastByte;
  initial
  begin
    for (int i = 0; i < 256; i++)
      cells[i] = i[7:0] ^ 8'h5A;
  end
  always @(posedge clk)
  begin
    if (programRead)
      lastWord <= programData;
    if (dataRead)
      lastByte <= dataReadValue;
    if (dataWrite)
      cells[dataAddress] <= dataWriteValue;
  end
endmodule
`default_nettype wire

/* File: verification/quad_phase_fetch_execute_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin totalChecks++; if ((g) !== (e)) begin nFail++; $display("wrong value %s exp %0h got %0h", n, e, g); end end
module quad_phase_fetch_execute_sequencer_tb
  import sequencer_pkg::*;
;
  logic        clk = 1'b0, rst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [9:0]  programAddress, fa, branchTarget = 10'h000;
  logic [11:0] programData, executeWord;
  logic [7:0]  dataAddress, dataWriteValue, dataReadValue, operandValue;
  logic [7:0]  operandAddress = 8'h01, resultValue = 8'h00;
  logic        programRead, dataRead, dataWrite, executeValid, wakeOnChange, w, e;
  logic        branchTaken = 1'b0, resultWrite = 1'b0;
  logic        phaseOne, phaseTwo, phaseThree, phaseFour;
  logic [5:0]  portBIn = 6'h00, portBOut, portBOe, portBPullup;
  int          nFail = 0, totalChecks = 0, i, m;
  logic [7:0]  offs [4] = '{CTRL_OFFSET, STATUS_OFFSET, POINTER_OFFSET, PORT_OFFSET};
  logic [31:0] rstv [4] = '{CTRL_RESET, {24'h0, STATUS_RESET}, {24'h0, POINTER_RESET}, {18'h0, TRIS_RESET, 8'h0}};
  logic [31:0] msk [4] = '{32'hFFFF_FFFF, 32'h0000_00F8, 32'h0000_00FF, 32'h0000_3F00};

  always #5 clk = ~clk;
  quad_phase_fetch_execute_sequencer dut (.*);
  fetch_memory_model mem (.*);

  task automatic testDone();
    if (nFail == 0 && totalChecks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic guard(input int k);
    if (k >= 40)
    begin
      nFail++;
      testDone();
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // ==========================================================================
  // Register bus master.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 40; k++)
    begin
      @(posedge clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
        break;
    end
    guard(k);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdr(input logic [7:0] a);
    int k;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 40; k++)
    begin
      @(posedge clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
        break;
    end
    guard(k);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask
  // Waits for fetch, phase three, operand read or result write.
  task automatic waitOn(input int s);
    int k;
    logic [3:0] v;
    for (k = 0; k < 40; k++)
    begin
      @(posedge clk);
      v = {dataWrite, dataRead, phaseThree, programRead};
      if (v[s])
        break;
    end
    guard(k);
    fa = programAddress;
  endtask
  task automatic branchTo(input logic [9:0] t);
    waitOn(1);
    branchTaken <= 1'b1;
    branchTarget <= t;
    @(posedge clk);
    branchTaken <= 1'b0;
    tick(2);
    `CHK("flush", 1'b0, executeValid)
    waitOn(0);
  endtask
  task automatic wakeSeen(input logic [5:0] p);
    portBIn <= p;
    w = 1'b0;
    repeat (6)
    begin
      @(posedge clk);
      w = w | wakeOnChange;
    end
  endtask

  initial
  begin
    tick(6);
    rst <= 1'b0;
    waitOn(0);
    `CHK("first fetch", 10'h000, fa)
    waitOn(0);
    `CHK("next fetch", 10'h001, fa)
    tick(1);
    `CHK("latched word", {fa, 2'b01}, executeWord)
    for (i = 0; i < 4; i++)
    begin
      rdr(offs[i]);
      `CHK("reset value", rstv[i], rd & msk[i])
    end
    wr(PCVIEW_OFFSET, 32'h1);
    `CHK("read-only write", AXI_SLVERR, rsp)
    rdr(8'h40);
    `CHK("unmapped read", AXI_SLVERR, rsp)
    for (m = 0; m < 4; m++)
    begin
      e = (m == 1 || m == 2);
      wr(CTRL_OFFSET, {29'h0, m[1:0], 1'b1});
      waitOn(1);
      tick(1);
      `CHK("clock enable", e, portBOe[QCLK_BIT])
      `CHK("clock high", e, portBOut[QCLK_BIT])
      tick(2);
      `CHK("clock low", 1'b0, portBOut[QCLK_BIT])
    end
    wr(CTRL_OFFSET, 32'h003F_3F01);
    tick(3);
    `CHK("pull-ups", WEAK_CAPABLE, portBPullup)
    wakeSeen(6'h04);
    `CHK("no wake", 1'b0, w)
    wakeSeen(6'h05);
    `CHK("wake", 1'b1, w)
    wr(CTRL_OFFSET, 32'h0000_0009);
    tick(3);
    `CHK("clear pull-up", 6'h08, portBPullup)
    wr(PORT_OFFSET, 32'h0000_003F);
    tick(3);
    `CHK("drivers", 6'h37, portBOe)
    rdr(PORT_OFFSET);
    `CHK("pin read", 6'h05, rd[5:0])
    wr(POINTER_OFFSET, 32'h4A);
    operandAddress <= 8'h00;
    waitOn(2);
    `CHK("indirect address", 8'h4A, dataAddress)
    tick(1);
    `CHK("operand", 8'h10, operandValue)
    resultValue <= 8'hC3;
    resultWrite <= 1'b1;
    operandAddress <= 8'h07;
    waitOn(3);
    resultWrite <= 1'b0;
    tick(1);
    `CHK("stored", 8'hC3, mem.cells[7])
    wr(STATUS_OFFSET, 32'h20);
    branchTo(10'h0FF);
    `CHK("paged target", 10'h2FF, fa)
    waitOn(0);
    `CHK("after target", 10'h300, fa)
    branchTo(10'h1FF);
    `CHK("top address", 10'h3FF, fa)
    waitOn(0);
    `CHK("wrapped", 10'h000, fa)
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    waitOn(0);
    `CHK("restart", 10'h000, fa)
    testDone();
  end
endmodule
`default_nettype wire
